//--- core/i2c_pin_sync.sv
`default_nettype none

module i2c_pin_sync #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q   <= '1;
      sync_out <= '1;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

//--- core/imu_i2c_cfg.svh
`ifndef IMU_I2C_CFG_SVH
`define IMU_I2C_CFG_SVH

// =====================================================================
// Target addresses, low and high strap level
`define ACC_ADDR_LO     7'h18
`define ACC_ADDR_HI     7'h19
`define GYR_ADDR_LO     7'h68
`define GYR_ADDR_HI     7'h69

// =====================================================================
// Register pointer and watchdog configuration byte
`define PTR_RESET       8'h00
`define WDT_CFG_REG     8'h34
`define WDT_EN_BIT      2
`define WDT_SEL_BIT     1

// =====================================================================
// Timing
`define CLK_MHZ         100
`define WDT_SHORT_US    1000
`define WDT_LONG_US     50000
`define WDT_SHORT_CYC   (`WDT_SHORT_US * `CLK_MHZ)
`define WDT_LONG_CYC    (`WDT_LONG_US * `CLK_MHZ)
`define STRAP_SETTLE    2'h3

`endif

//--- core/imu_i2c_pkg.sv
`default_nettype none

package imu_i2c_pkg;

  // ===================================================================
  // Which sensor answered
  typedef enum logic {
    SENS_ACC = 1'b0,
    SENS_GYR = 1'b1
  } sensor_t;

  // ===================================================================
  // Transaction sequencer
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h2,
    ST_REG       = 4'h3,
    ST_REG_ACK   = 4'h4,
    ST_WDATA     = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA     = 4'h7,
    ST_RACK      = 4'h8,
    ST_IGNORE    = 4'h9
  } seq_state_t;

  // ===================================================================
  // Register write seen on the bus
  typedef struct packed {
    sensor_t    sensor;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;

endpackage

`default_nettype wire

//--- core/imu_i2c_slave_port.sv
// Notes on behaviour
// - Target only, 7-bit addressing, no 10-bit
// - Accelerometer at 0x18, or 0x19 strapped high
// - Gyroscope at 0x68, or 0x69, own strap
// - Start/stop are SDA edges while SCL high
// - Stop right after start is not recognised
// - Receiver holds SDA low during ack clock
// - Write: address, register byte, data, all acked
// - Read: repeated start, then data from register
// - Master ack continues, nack ends, SDA released
// - Pointer increments after each byte read
// - Reads start at last written address, reset 0x00
// - Watchdog resets interface when device locks bus
// - Watchdog enable bit per sensor
// - Watchdog period 1 ms or 50 ms
`include "imu_i2c_cfg.svh"
`default_nettype none

module imu_i2c_slave_port #(
  parameter int unsigned WDT_SHORT_CYC = `WDT_SHORT_CYC,
  parameter int unsigned WDT_LONG_CYC  = `WDT_LONG_CYC
) (
  input  wire logic               core_clk,
  input  wire logic               arst_n,
  input  wire logic               serial_clock_pin,
  input  wire logic               serial_data_pin_in,
  output logic                    serial_data_pin_out,
  output logic                    serial_data_pin_oe,
  input  wire logic               acc_addr_strap,
  input  wire logic               gyr_addr_strap,
  output logic                    bus_busy,
  output imu_i2c_pkg::reg_write_t reg_write,
  output logic                    reg_write_valid,
  output logic                    wdt_fired
);
  import imu_i2c_pkg::*;

  localparam int unsigned WDW = $clog2(WDT_LONG_CYC + 1);
  localparam logic [WDW-1:0] WDT_SHORT_LIM = WDW'(WDT_SHORT_CYC - 1);
  localparam logic [WDW-1:0] WDT_LONG_LIM  = WDW'(WDT_LONG_CYC - 1);

  // ===================================================================
  // Pin synchronisers and edge detection
  logic [3:0] sync_w;
  logic       scl_s, sda_s, scl_prev_q, sda_prev_q;
  logic       scl_rise, scl_fall, start_det, stop_det;

  i2c_pin_sync #(
    .WIDTH (4)
  ) u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .async_in ({gyr_addr_strap, acc_addr_strap, serial_data_pin_in, serial_clock_pin}),
    .sync_out (sync_w)
  );

  assign scl_s = sync_w[0];
  assign sda_s = sync_w[1];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_prev_q;
  assign scl_fall  = ~scl_s & scl_prev_q;
  assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // ===================================================================
  // Address straps, caught once after reset release
  logic [1:0] strap_cnt_q;
  logic       strap_done_q, acc_alt_q, gyr_alt_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_cnt_q  <= 2'h0;
      strap_done_q <= 1'b0;
      acc_alt_q    <= 1'b0;
      gyr_alt_q    <= 1'b0;
    end else if (!strap_done_q) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == `STRAP_SETTLE) begin
        strap_done_q <= 1'b1;
        acc_alt_q    <= sync_w[2];
        gyr_alt_q    <= sync_w[3];
      end
    end
  end

  // Bit 1: hit, bit 0: sensor; only 7-bit compares exist
  function automatic logic [1:0] addr_match(input logic [6:0] a, input logic acc_alt,
                                            input logic gyr_alt);
    logic [6:0] acc_a;
    logic [6:0] gyr_a;
    acc_a = acc_alt ? `ACC_ADDR_HI : `ACC_ADDR_LO;
    gyr_a = gyr_alt ? `GYR_ADDR_HI : `GYR_ADDR_LO;
    if (a == acc_a) begin
      addr_match = {1'b1, SENS_ACC};
    end else if (a == gyr_a) begin
      addr_match = {1'b1, SENS_GYR};
    end else begin
      addr_match = 2'b00;
    end
  endfunction

  // ===================================================================
  // Sequencer
  seq_state_t state_q;
  logic [7:0] shift_q, ptr_q;
  logic [7:0] base_q [2];
  logic [3:0] cnt_q;
  sensor_t    sensor_q;
  logic       nack_q, saw_low_q, wdt_fire, stop_ok;
  logic [1:0] match_w;
  logic [7:0] rd_data_w;
  logic       byte_done, wr_fire;

  assign match_w   = addr_match(shift_q[7:1], acc_alt_q, gyr_alt_q);
  assign byte_done = scl_fall && (cnt_q == 4'h8);
  assign wr_fire   = (state_q == ST_WDATA) && byte_done;
  assign stop_ok   = stop_det && saw_low_q;

  // A clock low phase must separate start and stop
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      saw_low_q <= 1'b0;
    end else if (start_det) begin
      saw_low_q <= 1'b0;
    end else if (scl_fall) begin
      saw_low_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_busy <= 1'b0;
    end else if (start_det) begin
      bus_busy <= 1'b1;
    end else if (stop_ok) begin
      bus_busy <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q  <= ST_IDLE;
      shift_q  <= 8'h00;
      cnt_q    <= 4'h0;
      sensor_q <= SENS_ACC;
      nack_q   <= 1'b0;
    end else if (wdt_fire) begin
      state_q <= ST_IDLE;
    end else if (start_det) begin
      state_q <= ST_ADDR;
      cnt_q   <= 4'h0;
    end else if (stop_ok) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_ADDR, ST_REG, ST_WDATA: begin
          if (scl_rise && cnt_q != 4'h8) begin
            shift_q <= {shift_q[6:0], sda_s};
            cnt_q   <= cnt_q + 4'h1;
          end else if (byte_done) begin
            if (state_q == ST_ADDR) begin
              if (match_w[1]) begin
                sensor_q <= sensor_t'(match_w[0]);
                state_q  <= ST_ADDR_ACK;
              end else begin
                state_q <= ST_IGNORE;
              end
            end else if (state_q == ST_REG) begin
              state_q <= ST_REG_ACK;
            end else begin
              state_q <= ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            cnt_q <= 4'h0;
            if (shift_q[0]) begin
              state_q <= ST_RDATA;
              shift_q <= rd_data_w;
            end else begin
              state_q <= ST_REG;
            end
          end
        end
        ST_REG_ACK: begin
          if (scl_fall) begin
            state_q <= ST_WDATA;
            cnt_q   <= 4'h0;
          end
        end
        ST_WDATA_ACK: begin
          // Single data byte per write; later bytes are left unacked
          if (scl_fall) begin
            state_q <= ST_IGNORE;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (cnt_q == 4'h7) begin
              state_q <= ST_RACK;
            end else begin
              shift_q <= {shift_q[6:0], 1'b0};
              cnt_q   <= cnt_q + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            nack_q <= sda_s;
          end else if (scl_fall) begin
            if (nack_q) begin
              state_q <= ST_IGNORE;
            end else begin
              state_q <= ST_RDATA;
              shift_q <= rd_data_w;
              cnt_q   <= 4'h0;
            end
          end
        end
        ST_IGNORE, ST_IDLE: begin
          state_q <= state_q;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ===================================================================
  // Register pointer and per-sensor read start address
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_q     <= `PTR_RESET;
      base_q[0] <= `PTR_RESET;
      base_q[1] <= `PTR_RESET;
    end else if (!wdt_fire && !start_det && !stop_ok) begin
      if (state_q == ST_ADDR && byte_done && match_w[1]) begin
        ptr_q <= base_q[match_w[0]];
      end else if (state_q == ST_REG && byte_done) begin
        base_q[sensor_q] <= shift_q;
        ptr_q            <= shift_q;
      end else if (state_q == ST_RDATA && scl_fall && cnt_q == 4'h7) begin
        ptr_q <= ptr_q + 8'h01;
      end
    end
  end

  imu_reg_mem #(
    .AW (9),
    .DW (8)
  ) u_mem (
    .core_clk  (core_clk),
    .wr_en     (wr_fire),
    .wr_addr   ({sensor_q, ptr_q}),
    .wr_data   (shift_q),
    .rd_addr   ({sensor_q, ptr_q}),
    .rd_data_q (rd_data_w)
  );

  // ===================================================================
  // Write report and watchdog configuration capture
  logic [1:0] wdt_en_q, wdt_sel_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_write       <= '0;
      reg_write_valid <= 1'b0;
    end else begin
      reg_write_valid <= wr_fire && !wdt_fire && !start_det && !stop_ok;
      if (wr_fire) begin
        reg_write <= '{sensor: sensor_q, addr: ptr_q, data: shift_q};
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_en_q  <= 2'b00;
      wdt_sel_q <= 2'b00;
    end else if (wr_fire && !wdt_fire && !start_det && !stop_ok && ptr_q == `WDT_CFG_REG) begin
      wdt_en_q[sensor_q]  <= shift_q[`WDT_EN_BIT];
      wdt_sel_q[sensor_q] <= shift_q[`WDT_SEL_BIT];
    end
  end

  // ===================================================================
  // SDA drive and bus watchdog
  logic           oe_d;
  logic [WDW-1:0] wdt_cnt_q;
  logic [WDW-1:0] wdt_lim;

  // Open drain: only ever pull low
  assign oe_d = (state_q == ST_ADDR_ACK) || (state_q == ST_REG_ACK) ||
                (state_q == ST_WDATA_ACK) || (state_q == ST_RDATA && !shift_q[7]);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_data_pin_oe  <= 1'b0;
      serial_data_pin_out <= 1'b0;
    end else begin
      serial_data_pin_oe  <= oe_d && !wdt_fire;
      serial_data_pin_out <= 1'b0;
    end
  end

  // Counts only while the device itself holds SDA low
  assign wdt_lim  = wdt_sel_q[sensor_q] ? WDT_LONG_LIM : WDT_SHORT_LIM;
  assign wdt_fire = wdt_en_q[sensor_q] && serial_data_pin_oe && (wdt_cnt_q >= wdt_lim);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_cnt_q <= '0;
      wdt_fired <= 1'b0;
    end else begin
      wdt_fired <= wdt_fire;
      if (!serial_data_pin_oe || wdt_fire) begin
        wdt_cnt_q <= '0;
      end else if (wdt_cnt_q != '1) begin
        wdt_cnt_q <= wdt_cnt_q + WDW'(1);
      end
    end
  end

  // ===================================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_addr_hit;
    state_q == ST_ADDR && byte_done && match_w[1] && !wdt_fire && !start_det && !stop_ok;
  endsequence

  property p_addr_ack;
    s_addr_hit |=> state_q == ST_ADDR_ACK ##1 serial_data_pin_oe;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");

  property p_addr_miss;
    (state_q == ST_ADDR && byte_done && !match_w[1] && !wdt_fire && !start_det && !stop_ok)
      |=> state_q == ST_IGNORE ##1 !serial_data_pin_oe;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("unmatched address acked");

  property p_busy;
    start_det |=> bus_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not set on start");

  property p_bare_stop;
    (stop_det && !saw_low_q && bus_busy && !start_det) |=> bus_busy;
  endproperty
  a_bare_stop: assert property (p_bare_stop) else $error("bare stop recognised");

  property p_ack_hold;
    (scl_rise && (state_q == ST_REG_ACK || state_q == ST_WDATA_ACK)) |-> serial_data_pin_oe;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack not driven on clock high");

  property p_write;
    (wr_fire && !wdt_fire && !start_det && !stop_ok)
      |=> reg_write_valid && reg_write.data == $past(shift_q) ##1 !reg_write_valid;
  endproperty
  a_write: assert property (p_write) else $error("write not reported");

  property p_incr;
    (state_q == ST_RDATA && scl_fall && cnt_q == 4'h7 && !wdt_fire && !start_det && !stop_ok)
      |=> ptr_q == $past(ptr_q) + 8'h01;
  endproperty
  a_incr: assert property (p_incr) else $error("pointer not incremented");

  property p_nack;
    (state_q == ST_RACK && scl_fall && nack_q && !wdt_fire && !start_det && !stop_ok)
      |=> state_q == ST_IGNORE ##1 !serial_data_pin_oe;
  endproperty
  a_nack: assert property (p_nack) else $error("sda held after nack");

  property p_wdt;
    wdt_fire |=> state_q == ST_IDLE && wdt_fired ##1 !serial_data_pin_oe;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog did not reset");

endmodule

`default_nettype wire

//--- core/imu_reg_mem.sv
`default_nettype none

module imu_reg_mem #(
  parameter int unsigned AW = 9,
  parameter int unsigned DW = 8
) (
  input  wire logic          core_clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data_q
);

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read; uninitialised contents are not reset
  always_ff @(posedge core_clk) begin
    rd_data_q <= mem[rd_addr];
  end

endmodule

`default_nettype wire

//--- test/i2c_master_model.sv
`default_nettype none

module i2c_master_model (
  input  wire logic core_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_lo
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus: both lines released, SCL stands high between frames
  initial begin
    scl    = 1'b1;
    sda_lo = 1'b0;
  end

  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // ==========
  // Framing
  task automatic start();
    sda_lo <= 1'b0;
    w(4);
    scl <= 1'b1;
    w(8);
    sda_lo <= 1'b1;
    w(8);
    scl <= 1'b0;
    w(4);
  endtask

  task automatic stop();
    sda_lo <= 1'b1;
    w(4);
    scl <= 1'b1;
    w(8);
    sda_lo <= 1'b0;
    w(8);
  endtask

  // Only on command: start and stop with no clock between
  task automatic start_stop();
    sda_lo <= 1'b1;
    w(8);
    sda_lo <= 1'b0;
    w(8);
  endtask

  // ==========
  // Bits and bytes, SCL 8 cycles low and 8 high
  task automatic clk_bit(input logic b, output logic r);
    sda_lo <= ~b;
    w(4);
    scl <= 1'b1;
    w(4);
    r = sda;
    w(4);
    scl <= 1'b0;
    w(4);
  endtask

  // Ninth bit: released for a target ack, or our own ack or nack
  task automatic xfer(input logic [7:0] d, input logic ab,
                      output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r[i]);
    clk_bit(ab, ack);
  endtask
endmodule

`default_nettype wire

//--- test/test_imu_i2c_slave_port.sv
`default_nettype none

module test_imu_i2c_slave_port;
  timeunit 1ns;
  timeprecision 1ps;
  import imu_i2c_pkg::*;

  localparam int unsigned SHORT = 40;
  localparam int unsigned LONG  = 200;

  logic       core_clk  = 1'b0;
  logic       arst_n    = 1'b0;
  logic       acc_strap = 1'b0;
  logic       gyr_strap = 1'b0;
  logic       scl;
  logic       sda_lo;
  logic       sda;
  logic       sda_out;
  logic       sda_oe;
  logic       bus_busy;
  logic       wr_valid;
  logic       wdt_fired;
  reg_write_t reg_write;
  reg_write_t last_wr;
  logic [7:0] rd;
  logic       ack;
  int         mismatches  = 0;
  int         check_count = 0;
  int         wr_seen     = 0;
  int         wdt_seen    = 0;
  int         cycles      = 0;

  always #5 core_clk = ~core_clk;

  // Open drain with pull-up: high unless a party pulls low
  assign sda = ~(sda_lo | (sda_oe & ~sda_out));

  i2c_master_model m (
    .core_clk(core_clk), .sda(sda), .scl(scl), .sda_lo(sda_lo)
  );

  imu_i2c_slave_port #(.WDT_SHORT_CYC(SHORT), .WDT_LONG_CYC(LONG)) uut (
    .core_clk(core_clk), .arst_n(arst_n),
    .serial_clock_pin(scl), .serial_data_pin_in(sda),
    .serial_data_pin_out(sda_out), .serial_data_pin_oe(sda_oe),
    .acc_addr_strap(acc_strap), .gyr_addr_strap(gyr_strap),
    .bus_busy(bus_busy), .reg_write(reg_write),
    .reg_write_valid(wr_valid), .wdt_fired(wdt_fired)
  );

  // ==========
  // Monitors and hang limit
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (wr_valid === 1'b1) begin
      wr_seen <= wr_seen + 1;
      last_wr <= reg_write;
    end
    if (wdt_fired === 1'b1) wdt_seen <= wdt_seen + 1;
    if (cycles == 40000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========
  // Bus helpers
  task automatic do_reset(input logic a, input logic g);
    arst_n    <= 1'b0;
    acc_strap <= a;
    gyr_strap <= g;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (20) @(posedge core_clk);
  endtask

  task automatic addr(input logic [6:0] a, input logic rw, output logic ak);
    m.start();
    m.xfer({a, rw}, 1'b1, rd, ak);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d);
    int n;
    n = wr_seen;
    addr(a, 1'b0, ack);
    chk(17'(ack), 17'h0);
    m.xfer(r, 1'b1, rd, ack);
    chk(17'(ack), 17'h0);
    m.xfer(d, 1'b1, rd, ack);
    chk(17'(ack), 17'h0);
    m.stop();
    chk(17'(wr_seen - n), 17'h1);
    chk(last_wr, {a[6] ? SENS_GYR : SENS_ACC, r, d});
    m.w(250);
  endtask

  task automatic rdchk(input logic [6:0] a, input logic set, input logic [7:0] e0);
    if (set) begin
      addr(a, 1'b0, ack);
      m.xfer(8'h10, 1'b1, rd, ack);
      chk(17'(ack), 17'h0);
    end
    addr(a, 1'b1, ack);
    chk(17'(ack), 17'h0);
    m.xfer(8'hff, 1'b0, rd, ack);
    chk(17'(rd), 17'(e0));
    m.xfer(8'hff, 1'b1, rd, ack);
    chk(17'(rd), 17'(e0 ^ 8'hff));
    m.w(8);
    chk(17'(sda_oe), 17'h0);
    chk(17'(bus_busy), 17'h1);
    m.stop();
    chk(17'(bus_busy), 17'h0);
  endtask

  task automatic probe(input logic [6:0] a, input logic exp);
    addr(a, 1'b0, ack);
    chk(17'(ack), 17'(exp));
    m.xfer(8'h00, 1'b1, rd, ack);
    chk(17'(ack), 17'(exp));
    m.stop();
  endtask

  // Stall with the device acking, SCL held low
  task automatic wdt_try(input logic [7:0] cfg, input int hold, input int exp);
    int n;
    wr(7'h18, 8'h34, cfg);
    n = wdt_seen;
    m.start();
    for (int i = 7; i >= 0; i--) m.clk_bit(i == 5 || i == 4, ack);
    m.w(hold);
    chk(17'(wdt_seen - n), 17'(exp));
    chk(17'(sda_oe), 17'(exp == 0));
    m.clk_bit(1'b1, ack);
    m.stop();
  endtask

  // ==========
  // Scenarios
  task automatic t_busy();
    chk(17'(bus_busy), 17'h0);
    m.start_stop();
    chk(17'(bus_busy), 17'h1);
    m.start();
    chk(17'(bus_busy), 17'h1);
    m.stop();
    chk(17'(bus_busy), 17'h0);
    $display("test busy done");
  endtask

  // Both sensors written before reading: storage must stay apart
  task automatic t_rw();
    logic [6:0] a[2];
    a[0] = 7'h18;
    a[1] = 7'h68;
    for (int s = 0; s < 2; s++) begin
      wr(a[s], 8'h10, 8'ha5 ^ 8'(s));
      wr(a[s], 8'h11, ~(8'ha5 ^ 8'(s)));
    end
    for (int s = 0; s < 2; s++) begin
      rdchk(a[s], 1'b1, 8'ha5 ^ 8'(s));
      rdchk(a[s], 1'b0, 8'ha5 ^ 8'(s));
    end
    $display("test read write done");
  endtask

  task automatic t_other();
    probe(7'h19, 1'b1);
    probe(7'h69, 1'b1);
    probe(7'h78, 1'b1);
    probe(7'h20, 1'b1);
    $display("test foreign address done");
  endtask

  task automatic t_wdt();
    wdt_try(8'h04, 100, 1);
    wdt_try(8'h06, 100, 0);
    wdt_try(8'h06, 300, 1);
    wdt_try(8'h00, 300, 0);
    $display("test watchdog done");
  endtask

  // Gyro read start must fall back to register 0 after reset
  task automatic t_strap();
    wr(7'h68, 8'h00, 8'h3c);
    wr(7'h68, 8'h01, 8'hc3);
    do_reset(1'b1, 1'b1);
    rdchk(7'h69, 1'b0, 8'h3c);
    probe(7'h18, 1'b1);
    probe(7'h68, 1'b1);
    probe(7'h19, 1'b0);
    probe(7'h69, 1'b0);
    $display("test strap done");
  endtask

  initial begin
    do_reset(1'b0, 1'b0);
    t_busy();
    t_rw();
    t_other();
    t_wdt();
    t_strap();
    end_sim();
  end
endmodule

`default_nettype wire
